// *** verilog/rpca_pkg.sv ***
package rpca_pkg;

	// ==========================================================
	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] OFS_CTRL   = 8'h00; // Inbound window options
	localparam logic [7:0] OFS_BUSNUM = 8'h04; // Primary, secondary, subordinate
	localparam logic [7:0] OFS_BAR0   = 8'h08; // Root port BAR0 base
	localparam logic [7:0] OFS_TRANS  = 8'h0C; // Inbound translation base
	localparam logic [7:0] OFS_STATUS = 8'h10; // Sticky event status, read only
	localparam logic [7:0] OFS_CLEAR  = 8'h14; // Write one to clear, write only
	localparam logic [7:0] OFS_ENABLE = 8'h18; // Interrupt enables
	localparam logic [7:0] OFS_STATE  = 8'h1C; // Live block state

	// ==========================================================
	// Field positions
	localparam int CTRL_CONCEAL_BIT = 0;  // conceal_inbound_window
	localparam int CTRL_BAR64_BIT   = 1;  // 64-bit BAR selected
	localparam int CTRL_SIZE_LSB    = 4;  // log2 of BAR0 size, 5 bits
	localparam int BUS_PRI_LSB      = 0;
	localparam int BUS_SEC_LSB      = 8;
	localparam int BUS_SUB_LSB      = 16;
	localparam int EVT_TIMEOUT_BIT  = 0;  // Config timeout
	localparam int EVT_RANGE_BIT    = 1;  // Bus number out of range
	localparam int EVT_UPUR_BIT     = 2;  // Upstream answered with UR
	localparam int EVT_W            = 3;
	localparam int ECAM_BUS_LSB     = 20;
	localparam int ECAM_DEV_LSB     = 15;
	localparam int ECAM_FN_LSB      = 12;
	localparam int ECAM_REG_LSB     = 2;

	// ==========================================================
	// Reset values and encodings
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] BUSNUM_RST  = 32'h0000_0000;
	localparam logic [31:0] BAR0_RST    = 32'h0000_0000;
	localparam logic [31:0] TRANS_RST   = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES    = 32'hFFFF_FFFF;
	localparam logic [4:0]  SIZE_4GB    = 5'h1_F;      // Log2 value 31 stands for 4 GB
	localparam logic [1:0]  CPL_SC      = 2'h0;        // Successful completion
	localparam logic [1:0]  CPL_UR      = 2'h1;        // Unsupported request
	localparam logic [1:0]  AHB_NONSEQ  = 2'h2;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int CFG_TIMEOUT_US    = 50;
	localparam int CFG_TIMEOUT_CYC   = (CFG_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	localparam int TMR_W             = 20;

	// ==========================================================
	// Configuration sequencer states
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_LOCAL = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT  = 3'b011,
		ST_RESP  = 3'b100
	} rpca_state_type;

endpackage

// *** verilog/rpca_cfg_timer.sv ***
`timescale 1ns/1ns
module rpca_cfg_timer
#(
	parameter int LIMIT = 5000
)
(
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic run_i,
	output logic      expired_o
);
	import rpca_pkg::*;

	localparam logic [TMR_W-1:0] LAST = TMR_W'(LIMIT - 1);

	logic [TMR_W-1:0] cnt_ff;  // Cycles spent waiting
	logic [TMR_W-1:0] nxt_cnt; // Next count
	logic             hit;     // Count reached the limit

	// ==========================================================
	// Count while running, restart whenever idle
	assign hit       = run_i && (cnt_ff == LAST);
	assign nxt_cnt   = (run_i && !hit) ? cnt_ff + TMR_W'(1) : '0;
	assign expired_o = hit;

	// Counter register
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

endmodule

// *** verilog/rpca_root_port_cfg.sv ***
// Functional notes
// - Primary bus access configures local block
// - Secondary bus access issues type 0
// - Bus above secondary to subordinate: type 1
// - Out of range bus: no request, SLVERR
// - Read answered UR returns all ones
// - Write answered UR gets SLVERR
// - Concealed BAR0 reads zero, writes masked
// - 64-bit 4 GB BAR0 passes all, untranslated
// - Concealment shuts BAR0 unless it is 64-bit 4 GB
// - Unconfigured BAR0 answers upstream with UR; 64-bit 4 GB pass-all accepts without a base
// - Timer ends stalled config, SLVERR; only link requests are timed, not local ones
// - Config timeout raises interrupt
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module rpca_root_port_cfg
#(
	parameter int TIMEOUT_CYC = rpca_pkg::CFG_TIMEOUT_CYC
)
(
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// AHB-Lite register slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// ECAM request from processor side
	input  wire logic        ecam_valid_i,
	output logic             ecam_ready_o,
	input  wire logic [31:0] ecam_addr_i,
	input  wire logic        ecam_write_i,
	input  wire logic [31:0] ecam_wdata_i,
	output logic             ecam_rsp_valid_o,
	output logic             ecam_rsp_slverr_o,
	output logic      [31:0] ecam_rsp_rdata_o,
	// Local self-configuration port
	output logic             loc_valid_o,
	output logic             loc_write_o,
	output logic      [9:0]  loc_reg_o,
	output logic      [31:0] loc_wdata_o,
	input  wire logic        loc_done_i,
	input  wire logic [31:0] loc_rdata_i,
	// Configuration request toward the link
	output logic             cfg_valid_o,
	input  wire logic        cfg_ready_i,
	output logic             cfg_type1_o,
	output logic             cfg_write_o,
	output logic      [7:0]  cfg_bus_o,
	output logic      [4:0]  cfg_dev_o,
	output logic      [2:0]  cfg_fn_o,
	output logic      [9:0]  cfg_reg_o,
	output logic      [31:0] cfg_wdata_o,
	input  wire logic        cpl_valid_i,
	input  wire logic [1:0]  cpl_status_i,
	input  wire logic [31:0] cpl_data_i,
	// Upstream requests arriving from the link
	input  wire logic        up_valid_i,
	input  wire logic [31:0] up_addr_i,
	output logic             up_accept_o,
	output logic             up_ur_o,
	output logic      [31:0] up_axi_addr_o,
	// Interrupt
	output logic             irq_o
);
	import rpca_pkg::*;

	// ==========================================================
	// Register state
	logic [31:0]      ctrl_ff;      // Inbound window options
	logic [31:0]      busnum_ff;    // Bus number triple
	logic [31:0]      bar0_ff;      // BAR0 base address
	logic             bar0_set_ff;  // BAR0 has been given a base
	logic [31:0]      trans_ff;     // Translation base
	logic [EVT_W-1:0] sts_ff;       // Sticky events
	logic [EVT_W-1:0] en_ff;        // Interrupt enables
	logic [7:0]       dph_addr_ff;  // Data phase address
	logic             dph_wr_ff;    // Data phase is a write
	logic [31:0]      hrdata_ff;    // Read data register

	// ==========================================================
	// Sequencer state
	rpca_state_type   state_ff;     // Current state
	rpca_state_type   nxt_state;    // Next state
	logic [31:0]      req_addr_ff;  // Captured ECAM address
	logic             req_wr_ff;    // Captured direction
	logic [31:0]      req_wdata_ff; // Captured write data
	logic             req_type1_ff; // Link request is type 1
	logic             rsp_err_ff;   // Response carries SLVERR
	logic [31:0]      rsp_data_ff;  // Response read data
	logic             up_accept_ff; // Upstream accepted pulse
	logic             up_ur_ff;     // Upstream refused pulse
	logic [31:0]      up_axi_ff;    // Upstream AXI address

	// ==========================================================
	// Field helpers, used for both ECAM and bus register decode
	function automatic logic [7:0] byte_at(input logic [31:0] w, input int lsb);
		byte_at = w[lsb +: 8];
	endfunction

	wire [7:0] e_bus = byte_at(ecam_addr_i, ECAM_BUS_LSB);
	wire [7:0] pri   = byte_at(busnum_ff, BUS_PRI_LSB);
	wire [7:0] sec   = byte_at(busnum_ff, BUS_SEC_LSB);
	wire [7:0] sub   = byte_at(busnum_ff, BUS_SUB_LSB);

	wire hit_pri   = (e_bus == pri);
	wire hit_sec   = !hit_pri && (e_bus == sec);
	// above secondary up to subordinate gives type 1
	wire hit_sub   = !hit_pri && (e_bus > sec) && (e_bus <= sub);
	wire bus_bad   = !hit_pri && !hit_sec && !hit_sub;

	wire take_req  = ecam_valid_i && (state_ff == ST_IDLE);
	wire timed_out;
	wire up_hit;    // Upstream request lands in BAR0, decoded below
	wire cpl_ur    = cpl_valid_i && (cpl_status_i == CPL_UR);

	// ==========================================================
	// AHB-Lite decode
	wire       a_take  = hsel_i && hready_i && (htrans_i == AHB_NONSEQ);
	wire       d_wr    = dph_wr_ff;
	wire       wr_ctrl = d_wr && (dph_addr_ff == OFS_CTRL);
	wire       wr_bus  = d_wr && (dph_addr_ff == OFS_BUSNUM);
	wire       wr_bar  = d_wr && (dph_addr_ff == OFS_BAR0);
	wire       wr_tr   = d_wr && (dph_addr_ff == OFS_TRANS);
	wire       wr_clr  = d_wr && (dph_addr_ff == OFS_CLEAR);
	wire       wr_en   = d_wr && (dph_addr_ff == OFS_ENABLE);
	wire       conceal = ctrl_ff[CTRL_CONCEAL_BIT];
	wire       bar64   = ctrl_ff[CTRL_BAR64_BIT];
	wire [4:0] sz_log2 = ctrl_ff[CTRL_SIZE_LSB +: 5];
	// whole 32-bit space open, no translation
	wire       pass_all = bar64 && (sz_log2 == SIZE_4GB);

	// Read mux, address phase, captured into a flop
	logic [31:0] rd_mux;
	wire  [7:0]  a_ofs = haddr_i[7:0];
	wire         a_low = (haddr_i[31:8] == 24'h00_0000);
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (!a_low)
			rd_mux = 32'h0000_0000;
		else if (a_ofs == OFS_CTRL)
			rd_mux = ctrl_ff;
		else if (a_ofs == OFS_BUSNUM)
			rd_mux = busnum_ff;
		else if (a_ofs == OFS_BAR0)
			rd_mux = conceal ? 32'h0000_0000 : bar0_ff;
		else if (a_ofs == OFS_TRANS)
			rd_mux = trans_ff;
		else if (a_ofs == OFS_STATUS)
			rd_mux = {29'h0000_0000, sts_ff};
		else if (a_ofs == OFS_ENABLE)
			rd_mux = {29'h0000_0000, en_ff};
		else if (a_ofs == OFS_STATE)
			rd_mux = {27'h000_0000, bar0_set_ff, 1'b0, state_ff};
	end

	// Zero wait state slave, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_ff;

	// Address phase capture
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			dph_addr_ff <= 8'h00;
			dph_wr_ff   <= 1'b0;
			hrdata_ff   <= 32'h0000_0000;
		end
		else
		begin
			dph_addr_ff <= a_low ? a_ofs : 8'hFF;
			dph_wr_ff   <= a_take && hwrite_i && a_low;
			hrdata_ff   <= (a_take && !hwrite_i) ? rd_mux : hrdata_ff;
		end
	end

	// ==========================================================
	// Software registers; the core writes busnum only through
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctrl_ff   <= CTRL_RST;
			busnum_ff <= BUSNUM_RST;
			trans_ff  <= TRANS_RST;
			en_ff     <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_ff <= hwdata_i;
			if (wr_bus)
				busnum_ff <= {8'h00, hwdata_i[23:0]};
			if (wr_tr)
				trans_ff <= hwdata_i;
			if (wr_en)
				en_ff <= hwdata_i[EVT_W-1:0];
		end
	end

	// BAR0 base, masked under concealment
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bar0_ff     <= BAR0_RST;
			bar0_set_ff <= 1'b0;
		end
		// writes masked, base held at zero
		else if (conceal)
		begin
			bar0_ff     <= BAR0_RST;
			bar0_set_ff <= 1'b0;
		end
		else if (wr_bar)
		begin
			bar0_ff     <= hwdata_i;
			bar0_set_ff <= 1'b1;
		end
	end

	// ==========================================================
	// Sticky events; a new event beats a same-cycle clear
	wire [EVT_W-1:0] evt_set;
	assign evt_set[EVT_TIMEOUT_BIT] = timed_out;
	assign evt_set[EVT_RANGE_BIT]   = take_req && bus_bad;
	assign evt_set[EVT_UPUR_BIT]    = up_valid_i && !up_hit;
	wire [EVT_W-1:0] evt_clr = wr_clr ? hwdata_i[EVT_W-1:0] : '0;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sts_ff <= '0;
		else
			sts_ff <= (sts_ff & ~evt_clr) | evt_set;
	end

	assign irq_o = |(sts_ff & en_ff);

	// ==========================================================
	// Upstream BAR0 check
	// BAR0 is live unless concealed; under concealment only the 64-bit 4 GB pass-all still hits
	wire [31:0] win_mask = ALL_ONES >> (5'd31 - sz_log2) >> 1;
	wire        win_hit  = ((up_addr_i & ~win_mask) == (bar0_ff & ~win_mask));
	assign      up_hit   = pass_all || (bar0_set_ff && win_hit);
	wire [31:0] up_xlat  = pass_all ? up_addr_i
	                                : ((trans_ff & ~win_mask) | (up_addr_i & win_mask));

	// Upstream result flops
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			up_accept_ff <= 1'b0;
			up_ur_ff     <= 1'b0;
			up_axi_ff    <= 32'h0000_0000;
		end
		else
		begin
			up_accept_ff <= up_valid_i && up_hit;
			up_ur_ff     <= up_valid_i && !up_hit;
			up_axi_ff    <= (up_valid_i && up_hit) ? up_xlat : up_axi_ff;
		end
	end

	assign up_accept_o   = up_accept_ff;
	assign up_ur_o       = up_ur_ff;
	assign up_axi_addr_o = up_axi_ff;

	// ==========================================================
	// Configuration sequencer
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (ecam_valid_i)
				begin
					if (hit_pri)
						nxt_state = ST_LOCAL;
					else if (bus_bad)
						nxt_state = ST_RESP;
					else
						nxt_state = ST_ISSUE;
				end
			ST_LOCAL:
				if (loc_done_i)
					nxt_state = ST_RESP;
			ST_ISSUE:
				if (timed_out)
					nxt_state = ST_RESP;
				else if (cfg_ready_i)
					nxt_state = ST_WAIT;
			ST_WAIT:
				if (cpl_valid_i || timed_out)
					nxt_state = ST_RESP;
			ST_RESP:
				nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	rpca_cfg_timer #(.LIMIT(TIMEOUT_CYC)) u_timer
	(
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.run_i     ((state_ff == ST_ISSUE) || (state_ff == ST_WAIT)),
		.expired_o (timed_out)
	);

	// State and request capture
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_ff     <= ST_IDLE;
			req_addr_ff  <= 32'h0000_0000;
			req_wr_ff    <= 1'b0;
			req_wdata_ff <= 32'h0000_0000;
			req_type1_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (take_req)
			begin
				req_addr_ff  <= ecam_addr_i;
				req_wr_ff    <= ecam_write_i;
				req_wdata_ff <= ecam_wdata_i;
				// type 1 beyond the secondary bus
				req_type1_ff <= hit_sub;
			end
		end
	end

	// Response outcome
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rsp_err_ff  <= 1'b0;
			rsp_data_ff <= 32'h0000_0000;
		end
		else if (take_req && bus_bad)
		begin
			rsp_err_ff  <= 1'b1;
			rsp_data_ff <= 32'h0000_0000;
		end
		else if ((state_ff == ST_LOCAL) && loc_done_i)
		begin
			rsp_err_ff  <= 1'b0;
			rsp_data_ff <= req_wr_ff ? 32'h0000_0000 : loc_rdata_i;
		end
		else if (timed_out)
		begin
			rsp_err_ff  <= 1'b1;
			rsp_data_ff <= 32'h0000_0000;
		end
		else if ((state_ff == ST_WAIT) && cpl_valid_i)
		begin
			// write with UR is an error
			rsp_err_ff  <= req_wr_ff && cpl_ur;
			// read with UR gives all ones
			rsp_data_ff <= req_wr_ff ? 32'h0000_0000 : (cpl_ur ? ALL_ONES : cpl_data_i);
		end
	end

	// ==========================================================
	// Outputs
	assign ecam_ready_o      = (state_ff == ST_IDLE);
	assign ecam_rsp_valid_o  = (state_ff == ST_RESP);
	assign ecam_rsp_slverr_o = rsp_err_ff;
	assign ecam_rsp_rdata_o  = rsp_data_ff;

	// local access never reaches the link
	assign loc_valid_o = (state_ff == ST_LOCAL);
	assign loc_write_o = req_wr_ff;
	assign loc_reg_o   = req_addr_ff[ECAM_REG_LSB +: 10];
	assign loc_wdata_o = req_wdata_ff;

	// link request, type from the bus range
	assign cfg_valid_o = (state_ff == ST_ISSUE);
	assign cfg_type1_o = req_type1_ff;
	assign cfg_write_o = req_wr_ff;
	assign cfg_bus_o   = req_addr_ff[ECAM_BUS_LSB +: 8];
	assign cfg_dev_o   = req_addr_ff[ECAM_DEV_LSB +: 5];
	assign cfg_fn_o    = req_addr_ff[ECAM_FN_LSB +: 3];
	assign cfg_reg_o   = req_addr_ff[ECAM_REG_LSB +: 10];
	assign cfg_wdata_o = req_wdata_ff;

endmodule

// *** bench/rpca_root_port_cfg_sva.sv ***
`timescale 1ns/1ns
module rpca_cfg_chk
	import rpca_pkg::*;
#(
	parameter int TIMEOUT_CYC = 20
)
(
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        ecam_valid_i,
	input wire logic        ecam_ready_o,
	input wire logic        ecam_rsp_valid_o,
	input wire logic        ecam_rsp_slverr_o,
	input wire logic [31:0] ecam_rsp_rdata_o,
	input wire logic        loc_valid_o,
	input wire logic        loc_done_i,
	input wire logic        cfg_valid_o,
	input wire logic        cfg_ready_i,
	input wire logic        cfg_write_o,
	input wire logic [7:0]  cfg_bus_o,
	input wire logic [9:0]  cfg_reg_o,
	input wire logic        cpl_valid_i,
	input wire logic [1:0]  cpl_status_i,
	input wire logic        up_valid_i,
	input wire logic        up_accept_o,
	input wire logic        up_ur_o
);
	// Ceiling on a link request, timer plus response latency
	localparam int TMO_MAX = TIMEOUT_CYC + 4;
	// ==========================================================
	// One clock domain, reset disables all
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	take_busy_a: assert property (ecam_valid_i && ecam_ready_o |=> !ecam_ready_o)
		else $error("ecam ready high after take");
	rsp_single_a: assert property (ecam_rsp_valid_o |=> !ecam_rsp_valid_o)
		else $error("ecam response longer than one cycle");
	local_only_a: assert property (loc_valid_o |-> !cfg_valid_o)
		else $error("link request during local access");
	loc_hold_a: assert property (loc_valid_o && !loc_done_i |=> loc_valid_o)
		else $error("local request dropped early");
	cfg_hold_a: assert property (cfg_valid_o && !cfg_ready_i |=> $stable({cfg_bus_o, cfg_reg_o}))
		else $error("link request fields moved");
	ur_ones_a: assert property (cpl_valid_i && cpl_status_i == CPL_UR && !cfg_write_o
		&& !cfg_valid_o && !ecam_ready_o |=> ecam_rsp_valid_o && !ecam_rsp_slverr_o
		&& ecam_rsp_rdata_o == ALL_ONES)
		else $error("read with UR not all ones");
	ur_write_a: assert property (cpl_valid_i && cpl_status_i == CPL_UR && cfg_write_o
		&& !cfg_valid_o && !ecam_ready_o |=> ecam_rsp_valid_o && ecam_rsp_slverr_o)
		else $error("write with UR without error");
	tmo_bound_a: assert property ($rose(cfg_valid_o) |-> ##[1:TMO_MAX] ecam_rsp_valid_o)
		else $error("link request never ended");
	up_answer_a: assert property (up_valid_i |=> up_accept_o != up_ur_o)
		else $error("upstream request not answered once");
endmodule

// *** bench/rpca_link_model.sv ***
`timescale 1ns/1ns
module rpca_link_model
#(
	parameter logic [31:0] CPL_DAT = 32'h0000_0000,
	parameter logic [31:0] LOC_DAT = 32'h0000_0000
)
(
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic        cfg_valid_i,
	input  wire logic        loc_valid_i,
	output logic             cfg_ready_o,
	output logic             cpl_valid_o,
	output logic      [1:0]  cpl_status_o,
	output logic      [31:0] cpl_data_o,
	output logic             loc_done_o,
	output logic      [31:0] loc_rdata_o
);
	logic [3:0] wait_ff; // Cycles spent on the current step
	logic       pend_ff; // Request taken, completion owed
	logic [3:0] dly;     // Answer delay, mode 1 is slow
	assign dly = (mode_i == 2'h1) ? 4'h4 : 4'h1;
	// Off the pulse the data lines show the inverse, never a stale match
	assign cpl_data_o   = cpl_valid_o ? CPL_DAT : ~CPL_DAT;
	assign loc_rdata_o  = loc_done_o ? LOC_DAT : ~LOC_DAT;
	assign cpl_status_o = cpl_valid_o ? {1'h0, mode_i == 2'h2} : 2'h3;
	// Mode 3 never answers a link request, so the bridge must time out
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			{cfg_ready_o, cpl_valid_o, loc_done_o, pend_ff} <= 4'h0;
			wait_ff <= 4'h0;
		end
		else
		begin
			{cfg_ready_o, cpl_valid_o, loc_done_o} <= 3'h0;
			wait_ff <= wait_ff + 4'h1;
			if (cfg_valid_i && cfg_ready_o)
				{pend_ff, wait_ff} <= 5'h10;
			else if (pend_ff)
				{cpl_valid_o, pend_ff} <= (wait_ff >= dly) ? 2'h2 : 2'h1;
			else if (cfg_valid_i && mode_i != 2'h3)
				cfg_ready_o <= (wait_ff >= dly);
			else if (loc_valid_i && !loc_done_o)
				loc_done_o <= (wait_ff >= dly);
			else
				wait_ff <= 4'h0;
		end
endmodule

// *** bench/rpca_root_port_cfg_test.sv ***
`timescale 1ns/1ns
module rpca_root_port_cfg_test;
	import rpca_pkg::*;
	localparam logic [31:0] CPL_DAT = 32'h5A5A_1234; // Link read data
	localparam logic [31:0] LOC_DAT = 32'h0F0F_A5A5; // Local read data
	logic        clk_i, arst_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
	logic        ecam_valid_i, ecam_write_i, ecam_ready_o, ecam_rsp_valid_o, ecam_rsp_slverr_o;
	logic        loc_valid_o, loc_write_o, loc_done_i, cfg_valid_o, cfg_ready_i, cfg_type1_o;
	logic        cfg_write_o, cpl_valid_i, up_valid_i, up_accept_o, up_ur_o, irq_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, ecam_addr_i, ecam_wdata_i, ecam_rsp_rdata_o;
	logic [31:0] loc_wdata_o, loc_rdata_i, cfg_wdata_o, cpl_data_i, up_addr_i, up_axi_addr_o;
	logic [9:0]  loc_reg_o, cfg_reg_o;
	logic [7:0]  cfg_bus_o;
	logic [4:0]  cfg_dev_o;
	logic [2:0]  cfg_fn_o, hsize_i;
	logic [1:0]  htrans_i, cpl_status_i, mode;
	logic [26:0] seen; // Last link request header
	int          ncfg, nloc, bad_count, total_checks;
	assign hready_i = hreadyout_o;
	rpca_root_port_cfg #(.TIMEOUT_CYC(20)) rpca_root_port_cfg_inst (.clk_i, .arst_n_i, .hsel_i,
		.haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
		.hresp_o, .ecam_valid_i, .ecam_ready_o, .ecam_addr_i, .ecam_write_i, .ecam_wdata_i,
		.ecam_rsp_valid_o, .ecam_rsp_slverr_o, .ecam_rsp_rdata_o, .loc_valid_o, .loc_write_o,
		.loc_reg_o, .loc_wdata_o, .loc_done_i, .loc_rdata_i, .cfg_valid_o, .cfg_ready_i,
		.cfg_type1_o, .cfg_write_o, .cfg_bus_o, .cfg_dev_o, .cfg_fn_o, .cfg_reg_o, .cfg_wdata_o,
		.cpl_valid_i, .cpl_status_i, .cpl_data_i, .up_valid_i, .up_addr_i, .up_accept_o,
		.up_ur_o, .up_axi_addr_o, .irq_o);
	rpca_link_model #(.CPL_DAT(CPL_DAT), .LOC_DAT(LOC_DAT)) rpca_link_model_inst (.clk_i,
		.arst_n_i, .mode_i(mode), .cfg_valid_i(cfg_valid_o), .loc_valid_i(loc_valid_o),
		.cfg_ready_o(cfg_ready_i), .cpl_valid_o(cpl_valid_i), .cpl_status_o(cpl_status_i),
		.cpl_data_o(cpl_data_i), .loc_done_o(loc_done_i), .loc_rdata_o(loc_rdata_i));
	// ==========================================================
	// Clock, request monitor, watchdog
	initial
	begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		if (cfg_valid_o && cfg_ready_i)
			{ncfg, seen} = {ncfg + 1, cfg_type1_o, cfg_bus_o, cfg_dev_o, cfg_fn_o, cfg_reg_o};
		if (loc_valid_o && loc_done_i)
			nloc++;
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		conclude;
	end
	// ==========================================================
	// Shared tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		{hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'h1, AHB_NONSEQ, 24'h0, a, w};
		do @(posedge clk_i); while (hready_i !== 1'h1);
		{hsel_i, htrans_i, hwdata_i} <= {3'h0, d};
		do @(posedge clk_i); while (hready_i !== 1'h1);
		q = hrdata_o;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'h1, a, d, q);
		@(posedge clk_i);
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		ahb(1'h0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	// Device 3, function 2, register 0x15 on the given bus
	task ecam(input logic w, input logic [7:0] b, input logic [1:0] m, output logic e,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		{mode, ecam_valid_i, ecam_write_i} <= {m, 1'h1, w};
		ecam_addr_i <= {4'h0, b, 5'h03, 3'h2, 10'h015, 2'h0};
		do @(posedge clk_i); while (ecam_ready_o !== 1'h1);
		ecam_valid_i <= 1'h0;
		n = 0;
		do begin @(posedge clk_i); n++; end while (ecam_rsp_valid_o !== 1'h1 && n < 200);
		{e, q} = {ecam_rsp_slverr_o, ecam_rsp_rdata_o};
		chk("ecam_answered", 1, n < 200);
	endtask
	task upr(input logic [31:0] a, output logic [33:0] r);
		@(posedge clk_i);
		{up_valid_i, up_addr_i} <= {1'h1, a};
		@(posedge clk_i);
		{up_valid_i, up_addr_i} <= {1'h0, ~a};
		@(posedge clk_i);
		r = {up_accept_o, up_ur_o, up_axi_addr_o};
	endtask
	// ==========================================================
	// Scenarios
	task t_regs;
		rd("ctrl_rst", OFS_CTRL, CTRL_RST);
		rd("bus_rst", OFS_BUSNUM, BUSNUM_RST);
		rd("bar_rst", OFS_BAR0, BAR0_RST);
		rd("stat_rst", OFS_STATUS, 32'h0000_0000);
		wr(8'h40, ALL_ONES);
		rd("unmapped", 8'h40, 32'h0000_0000);
	endtask
	task t_route;
		logic e;
		logic [31:0] q;
		logic [7:0] b;
		int c;
		wr(OFS_BUSNUM, 32'h0004_0100);
		c = ncfg;
		ecam(1'h0, 8'h00, 2'h0, e, q);
		chk("local_data", LOC_DAT, q);
		chk("local_link", c, ncfg);
		chk("local_done", 1, nloc);
		for (int i = 0; i < 3; i++)
		begin
			b = (i == 2) ? 8'h04 : 8'(i + 1);
			ecam(1'h0, b, 2'(i % 2), e, q);
			chk("link_hdr", {5'h0, b != 8'h01, b, 5'h03, 3'h2, 10'h015}, {5'h0, seen});
			chk("link_data", CPL_DAT, q);
		end
		c = ncfg;
		ecam(1'h1, 8'h05, 2'h0, e, q);
		chk("range_err", 1, e);
		chk("range_link", c, ncfg);
	endtask
	task t_ur;
		logic e;
		logic [31:0] q;
		ecam(1'h0, 8'h01, 2'h2, e, q);
		chk("ur_rd_data", ALL_ONES, q);
		chk("ur_rd_err", 0, e);
		ecam(1'h1, 8'h04, 2'h2, e, q);
		chk("ur_wr_err", 1, e);
	endtask
	task t_tmo;
		logic e;
		logic [31:0] q;
		ecam(1'h0, 8'h02, 2'h3, e, q);
		chk("tmo_err", 1, e);
		rd("tmo_stat", OFS_STATUS, 32'h0000_0003);
		chk("irq_masked", 0, irq_o);
		wr(OFS_ENABLE, 32'h0000_0001);
		chk("irq_on", 1, irq_o);
		wr(OFS_CLEAR, 32'h0000_0007);
		rd("stat_clr", OFS_STATUS, 32'h0000_0000);
		chk("irq_off", 0, irq_o);
	endtask
	task t_up;
		logic [33:0] r;
		upr(32'h8765_4320, r);
		chk("up_unconf", 2'h1, r[33:32]);
		rd("up_stat", OFS_STATUS, 32'h0000_0004);
		wr(OFS_CTRL, 32'h0000_01F3);
		wr(OFS_BAR0, 32'hABCD_0000);
		rd("bar_hidden", OFS_BAR0, 32'h0000_0000);
		upr(32'h8765_4320, r);
		chk("up_pass", {2'h2, 32'h8765_4320}, r);
	endtask
	task conclude;
		if (bad_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		{arst_n_i, hsel_i, hwrite_i, ecam_valid_i, ecam_write_i, up_valid_i} = 6'h0;
		{haddr_i, hwdata_i, ecam_addr_i, ecam_wdata_i, up_addr_i} = 160'h0;
		{htrans_i, mode, hsize_i} = 7'h2;
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'h1;
		t_regs;
		t_route;
		t_ur;
		t_tmo;
		t_up;
		conclude;
	end
endmodule
bind rpca_root_port_cfg rpca_cfg_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) rpca_cfg_chk_inst (.clk_i,
	.arst_n_i, .ecam_valid_i, .ecam_ready_o, .ecam_rsp_valid_o, .ecam_rsp_slverr_o,
	.ecam_rsp_rdata_o, .loc_valid_o, .loc_done_i, .cfg_valid_o, .cfg_ready_i, .cfg_write_o,
	.cfg_bus_o, .cfg_reg_o, .cpl_valid_i, .cpl_status_i, .up_valid_i, .up_accept_o, .up_ur_o);
